// ==== common/ifsm_pkg.sv ====
// Purpose: Constants for the input fault status monitor register bank
// Assumes: Byte-wide registers on a 16-bit register address
// Notes: Offsets are register addresses on the serial control port

package ifsm_pkg;

  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [15:0] OFS_LIVE_STATUS_A = 16'h000C;
  localparam logic [15:0] OFS_LIVE_STATUS_INPUTS = 16'h000D;
  localparam logic [15:0] OFS_STICKY_FLAGS_A = 16'h0011;
  localparam logic [15:0] OFS_STICKY_FLAGS_INPUTS = 16'h0012;
  localparam logic [15:0] OFS_INTR_MASK_A = 16'h0017;
  localparam logic [15:0] OFS_INTR_MASK_INPUTS = 16'h0018;
  localparam logic [15:0] OFS_PRESCALER = 16'h0206;
  localparam logic [15:0] OFS_EXT_REF_CLOCK = 16'h090E;
  localparam logic [15:0] OFS_INPUT_ENABLES = 16'h0949;

  // ******************************************************************
  // Field positions in the first status, flag and mask registers
  // ******************************************************************
  localparam int BIT_CAL_ACTIVE = 0;
  localparam int BIT_CRYSTAL_LOSS = 1;
  localparam int BIT_SEL_REF_LOSS = 2;
  localparam int BIT_PLL_UNLOCKED = 3;
  localparam int BIT_BUS_TIMEOUT = 5;
  // Implemented bits of the first status group
  localparam logic [7:0] MASK_GROUP_A = 8'h2F;
  // Implemented bits of the per-input group
  localparam logic [7:0] MASK_GROUP_INPUTS = 8'h0F;

  // Per-input loss positions: feedback on bit 3, then inputs 2, 1, 0
  localparam int BIT_FEEDBACK_IN = 3;

  // Reference select codes
  localparam logic [1:0] SEL_IN0 = 2'h0;
  localparam logic [1:0] SEL_IN1 = 2'h1;
  localparam logic [1:0] SEL_IN2 = 2'h2;
  localparam logic [1:0] SEL_CRYSTAL = 2'h3;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [3:0] RST_INPUT_ENABLES = 4'hF;
  localparam logic EXT_REF_RST = 1'b0;
  localparam logic [1:0] RST_PRESCALER = 2'h0;
  localparam logic [7:0] RST_MASK_A = 8'h00;
  localparam logic [7:0] RST_MASK_INPUTS = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

endpackage : ifsm_pkg

// ==== rtl/ifsm_monitor.sv ====
// Purpose: Status, sticky flag and input enable registers of a clock
//   generator, with lock-loss and interrupt pins
// Assumes: Monitored conditions are asynchronous levels; register port
//   is in the clk_sys domain
// Notes: Read data is registered, one cycle after the read strobe

// ********************************************************************
// Register bank
// ********************************************************************

// Notes on behaviour
// - Crystal or external clock on crystal pins chosen by register bit.
// - Four input enables reset to all on; clearing one disables input.
// - Status readable in registers; lock loss also on active-low pin.
// - Faults reported in registers and on lock-loss and interrupt pins.
// - Every status bit has a sticky flag set while status asserted.
// - Writing zero clears a sticky flag; writing one leaves it alone.
// - Status bit 0 reads one during calibration.
// - Status bit 1 shows crystal-pin signal loss, first pin only.
// - Status bit 2 shows signal loss on the selected reference.
// - Status bit 3 shows the PLL unlocked.
// - Status bit 5 shows a serial bus timeout.
// - Second status register: per-input loss, feedback bit 3 down to in0.
// - First flag register holds flags at bits 0,1,2,3,5.
// - Second flag register holds per-input loss flags, same bit order.
// - A flag clears only while its live status bit is low.
// - Interrupt pin low when any unmasked sticky flag is set.
// - External clock select resets to zero, crystal operation.
module ifsm_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register access port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // Monitored conditions, asynchronous levels
  input wire logic calibration_active,
  input wire logic crystal_pin_signal_loss,
  input wire logic pll_unlocked,
  input wire logic bus_timeout,
  input wire logic [3:0] per_input_signal_loss,
  input wire logic [1:0] ref_select,
  // Configuration outputs
  output logic ext_ref_clock_select,
  output logic [1:0] crystal_pin_prescaler,
  output logic [3:0] input_enable,
  // Board pins
  output logic unlocked_pin_n,
  output logic interrupt_pin_n
);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [7:0] status_a;
    logic [7:0] status_in;
    logic [7:0] flags_a;
    logic [7:0] flags_in;
    logic [7:0] mask_a;
    logic [7:0] mask_in;
    logic ext_ref;
    logic [1:0] prescaler;
    logic [3:0] in_en;
    logic [7:0] rd_data;
    logic unlocked_n;
    logic intr_n;
  } ifsm_state_t;

  ifsm_state_t state_reg;
  ifsm_state_t state_next;

  // Write strobe for one register offset
  function automatic logic hit(input logic [15:0] addr,
                               input logic [15:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Sticky update: live high sets, written zero clears only when low
  function automatic logic [7:0] sticky(input logic [7:0] flags,
                                        input logic [7:0] live,
                                        input logic wr,
                                        input logic [7:0] data,
                                        input logic [7:0] impl);
    logic [7:0] clr;
    clr = wr ? (~data & ~live) : 8'h00;
    sticky = ((flags & ~clr) | live) & impl;
  endfunction

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    logic [7:0] live_a;
    logic [7:0] live_in;
    logic sel_loss;
    live_a = 8'h00;
    live_in = 8'h00;
    sel_loss = 1'b0;
    state_next = state_reg;

    // Two-stage synchronisers for the asynchronous conditions
    state_next.sync1 = {ref_select, per_input_signal_loss, bus_timeout,
                        pll_unlocked, crystal_pin_signal_loss,
                        calibration_active};
    state_next.sync2 = state_reg.sync1;

    // Selected reference loss from the synchronised select
    case (state_reg.sync2[9:8])
      ifsm_pkg::SEL_IN0: sel_loss = state_reg.sync2[4];
      ifsm_pkg::SEL_IN1: sel_loss = state_reg.sync2[5];
      ifsm_pkg::SEL_IN2: sel_loss = state_reg.sync2[6];
      ifsm_pkg::SEL_CRYSTAL: sel_loss = state_reg.sync2[1];
      default: sel_loss = 1'b0;
    endcase

    // Live status, tracking conditions every cycle
    live_a[ifsm_pkg::BIT_CAL_ACTIVE] = state_reg.sync2[0];
    live_a[ifsm_pkg::BIT_CRYSTAL_LOSS] = state_reg.sync2[1];
    live_a[ifsm_pkg::BIT_SEL_REF_LOSS] = sel_loss;
    live_a[ifsm_pkg::BIT_PLL_UNLOCKED] = state_reg.sync2[2];
    live_a[ifsm_pkg::BIT_BUS_TIMEOUT] = state_reg.sync2[3];
    live_in[3:0] = state_reg.sync2[7:4];
    state_next.status_a = live_a;
    state_next.status_in = live_in;

    // Sticky flags, set wins over a clear in the same cycle
    state_next.flags_a = sticky(state_reg.flags_a, state_reg.status_a,
      reg_wr_en && hit(reg_addr, ifsm_pkg::OFS_STICKY_FLAGS_A),
      reg_wr_data, ifsm_pkg::MASK_GROUP_A);
    state_next.flags_in = sticky(state_reg.flags_in, state_reg.status_in,
      reg_wr_en && hit(reg_addr, ifsm_pkg::OFS_STICKY_FLAGS_INPUTS),
      reg_wr_data, ifsm_pkg::MASK_GROUP_INPUTS);

    // Writable configuration; status offsets take no writes
    if (reg_wr_en) begin
      if (hit(reg_addr, ifsm_pkg::OFS_INTR_MASK_A)) begin
        state_next.mask_a = reg_wr_data & ifsm_pkg::MASK_GROUP_A;
      end
      if (hit(reg_addr, ifsm_pkg::OFS_INTR_MASK_INPUTS)) begin
        state_next.mask_in = reg_wr_data & ifsm_pkg::MASK_GROUP_INPUTS;
      end
      if (hit(reg_addr, ifsm_pkg::OFS_EXT_REF_CLOCK)) begin
        state_next.ext_ref = reg_wr_data[0];
      end
      if (hit(reg_addr, ifsm_pkg::OFS_PRESCALER)) begin
        state_next.prescaler = reg_wr_data[1:0];
      end
      if (hit(reg_addr, ifsm_pkg::OFS_INPUT_ENABLES)) begin
        state_next.in_en = reg_wr_data[3:0];
      end
    end

    // Registered read data, zero for unmapped offsets
    if (reg_rd_en) begin
      case (reg_addr)
        ifsm_pkg::OFS_LIVE_STATUS_A:
          state_next.rd_data = state_reg.status_a;
        ifsm_pkg::OFS_LIVE_STATUS_INPUTS:
          state_next.rd_data = state_reg.status_in;
        ifsm_pkg::OFS_STICKY_FLAGS_A: state_next.rd_data = state_reg.flags_a;
        ifsm_pkg::OFS_STICKY_FLAGS_INPUTS:
          state_next.rd_data = state_reg.flags_in;
        ifsm_pkg::OFS_INTR_MASK_A: state_next.rd_data = state_reg.mask_a;
        ifsm_pkg::OFS_INTR_MASK_INPUTS:
          state_next.rd_data = state_reg.mask_in;
        ifsm_pkg::OFS_EXT_REF_CLOCK:
          state_next.rd_data = {7'h00, state_reg.ext_ref};
        ifsm_pkg::OFS_PRESCALER:
          state_next.rd_data = {6'h00, state_reg.prescaler};
        ifsm_pkg::OFS_INPUT_ENABLES:
          state_next.rd_data = {4'h0, state_reg.in_en};
        default: state_next.rd_data = 8'h00;
      endcase
    end

    // Board pins from live lock state and unmasked flags
    state_next.unlocked_n =
      ~state_reg.status_a[ifsm_pkg::BIT_PLL_UNLOCKED];
    state_next.intr_n =
      ~(|(state_reg.flags_a & ~state_reg.mask_a) |
        |(state_reg.flags_in & ~state_reg.mask_in));

    // Synchronous reset to constants
    if (srst) begin
      state_next = '0;
      state_next.flags_a = ifsm_pkg::RST_FLAGS;
      state_next.flags_in = ifsm_pkg::RST_FLAGS;
      state_next.mask_a = ifsm_pkg::RST_MASK_A;
      state_next.mask_in = ifsm_pkg::RST_MASK_INPUTS;
      state_next.ext_ref = ifsm_pkg::EXT_REF_RST;
      state_next.prescaler = ifsm_pkg::RST_PRESCALER;
      state_next.in_en = ifsm_pkg::RST_INPUT_ENABLES;
      state_next.unlocked_n = 1'b1;
      state_next.intr_n = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign reg_rd_data = state_reg.rd_data;
  assign ext_ref_clock_select = state_reg.ext_ref;
  assign crystal_pin_prescaler = state_reg.prescaler;
  assign input_enable = state_reg.in_en;
  assign unlocked_pin_n = state_reg.unlocked_n;
  assign interrupt_pin_n = state_reg.intr_n;

endmodule // ifsm_monitor

// ==== tb/ifsm_checker.sv ====
// Purpose: Port assertions for ifsm_monitor
// Assumes: Only top-level ports are seen
// Notes: Bound to every ifsm_monitor
module ifsm_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // Condition and outputs
  input wire logic pll_unlocked,
  input wire logic ext_ref_clock_select,
  input wire logic [1:0] crystal_pin_prescaler,
  input wire logic [3:0] input_enable,
  input wire logic unlocked_pin_n,
  input wire logic interrupt_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Checks
  // ****************
  logic mapped;
  logic rd_c;
  // Decoded addresses
  assign mapped = reg_addr inside {16'h000C, 16'h000D, 16'h0011, 16'h0012,
    16'h0017, 16'h0018, 16'h0206, 16'h090E, 16'h0949};
  assign rd_c = reg_rd_en && reg_addr == 16'h000C;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_pin_low: assert property (
    pll_unlocked[*6] |-> !unlocked_pin_n) else $error("pin not low");
  chk_pin_high: assert property (
    !pll_unlocked[*6] |-> unlocked_pin_n) else $error("pin not high");
  chk_reset_vals: assert property ($fell(srst) |->
    input_enable == 4'hF && !ext_ref_clock_select && interrupt_pin_n
    && crystal_pin_prescaler == 2'h0 && unlocked_pin_n)
    else $error("bad reset values");
  chk_rd_unmapped: assert property (
    reg_rd_en && !mapped |=> reg_rd_data == 8'h00) else $error("unmapped");
  chk_rd_hold: assert property (
    !reg_rd_en |=> $stable(reg_rd_data)) else $error("read data moved");
  chk_status_bits: assert property (
    rd_c |=> reg_rd_data[7:6] == 2'h0 && !reg_rd_data[4])
    else $error("status spare bit set");
  chk_wr_enable: assert property (
    reg_wr_en && reg_addr == 16'h0949
    |=> {4'h0, input_enable} == ($past(reg_wr_data) & 8'h0F))
    else $error("enables not written");
  chk_wr_extref: assert property (
    reg_wr_en && reg_addr == 16'h090E
    |=> ext_ref_clock_select == |($past(reg_wr_data) & 8'h01))
    else $error("select not written");
  chk_intr_release: assert property ($rose(interrupt_pin_n) |->
    $past(reg_wr_en) || $past(reg_wr_en, 2)) else $error("irq released");
  cov_rd: cover property (rd_c);
  cov_irq: cover property ($fell(interrupt_pin_n));
  cov_lock: cover property ($fell(unlocked_pin_n));
endmodule // ifsm_checker
bind ifsm_monitor ifsm_checker chk_u (.clk_sys, .srst, .reg_addr,
  .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .pll_unlocked,
  .ext_ref_clock_select, .crystal_pin_prescaler, .input_enable,
  .unlocked_pin_n, .interrupt_pin_n);

// ==== tb/ifsm_host_model.sv ====
// Purpose: Host on the register port
// Assumes: One-cycle strobes, data a cycle later
// Notes: Released address and data lines show inverted values; strobes go low
module ifsm_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [15:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // One access, held for its taking edge
  task automatic xfer(input logic [15:0] a, input logic w,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = w;
    reg_rd_en = !w;
    @(posedge clk_sys);
    #1;
    q = reg_rd_data;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
endmodule // ifsm_host_model

// ==== tb/ifsm_monitor_tb_top.sv ====
// Purpose: Self-checking bench for ifsm_monitor
// Assumes: Conditions are levels driven by the bench
// Notes: Ends through report_and_stop
module ifsm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [11:0] cnd = 12'h000;
  logic [1:0] ref_select = 2'h0;
  logic [15:0] reg_addr;
  logic reg_wr_en, reg_rd_en, sl, ext_ref_clock_select;
  logic unlocked_pin_n, interrupt_pin_n;
  logic [7:0] reg_wr_data, reg_rd_data, q, ea, ei;
  logic [1:0] crystal_pin_prescaler;
  logic [3:0] input_enable;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pos [8] = '{0, 3, 5, 1, 8, 9, 10, 11};
  always #20 clk_sys = ~clk_sys;
  ifsm_host_model host_u (.clk_sys, .reg_addr, .reg_wr_en, .reg_wr_data,
    .reg_rd_en, .reg_rd_data);
  ifsm_monitor dut_u (.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data,
    .reg_rd_en, .reg_rd_data, .calibration_active(cnd[0]),
    .crystal_pin_signal_loss(cnd[1]), .pll_unlocked(cnd[3]),
    .bus_timeout(cnd[5]), .per_input_signal_loss(cnd[11:8]), .ref_select,
    .ext_ref_clock_select, .crystal_pin_prescaler, .input_enable,
    .unlocked_pin_n, .interrupt_pin_n);
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host_u.xfer(a, 1'b0, 8'h00, q);
    chk($sformatf("rd %h", a), e, q);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_u.xfer(a, 1'b1, d, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    wt(5);
    srst = 1'b0;
    chk("ena", 8'h0F, {4'h0, input_enable});
    chk("pins", 8'h03, {6'h00, unlocked_pin_n, interrupt_pin_n});
    rd(16'h090E, 8'h00);
    wr(16'h090E, 8'h01);
    wr(16'h0949, 8'h05);
    wr(16'h0206, 8'h03);
    chk("ext", 8'h01, {7'h00, ext_ref_clock_select});
    chk("psc", 8'h03, {6'h00, crystal_pin_prescaler});
    host_u.xfer(16'h0949, 1'b0, 8'h00, q);
    chk("ena", 8'h05, q & 8'h0F);
    wr(16'h000C, 8'hFF);
    rd(16'h000C, 8'h00);
    rd(16'h0123, 8'h00);
    foreach (pos[k]) begin
      ref_select = k[1:0];
      cnd = 12'h001 << pos[k];
      sl = (ref_select == 2'h3) ? cnd[1] : cnd[8 + ref_select];
      ea = (cnd[7:0] | {5'h00, sl, 2'h0}) & 8'h2F;
      ei = {4'h0, cnd[11:8]};
      wt(6);
      rd(16'h000C, ea);
      rd(16'h000D, ei);
      chk("lck", {7'h00, !cnd[3]}, {7'h00, unlocked_pin_n});
      chk("irq", 8'h00, {7'h00, interrupt_pin_n});
      wr(16'h0011, 8'h00);
      wr(16'h0012, 8'h00);
      rd(16'h0011, ea);
      rd(16'h0012, ei);
      cnd = 12'h000;
      wt(6);
      rd(16'h000C, 8'h00);
      wr(16'h0011, 8'hFF);
      wr(16'h0012, 8'hFF);
      rd(16'h0011, ea);
      rd(16'h0012, ei);
      wr(16'h0011, 8'h00);
      wr(16'h0012, 8'h00);
      rd(16'h0011, 8'h00);
      rd(16'h0012, 8'h00);
      chk("irq", 8'h01, {7'h00, interrupt_pin_n});
    end
    wr(16'h0017, 8'hFF);
    cnd = 12'h008;
    wt(6);
    chk("msk", 8'h01, {7'h00, interrupt_pin_n});
    wr(16'h0017, 8'h00);
    wt(1);
    chk("unm", 8'h00, {7'h00, interrupt_pin_n});
    rd(16'h0017, 8'h00);
    wr(16'h0018, 8'hFF);
    rd(16'h0018, 8'h0F);
    cnd = 12'h100;
    wt(6);
    rd(16'h0012, 8'h01);
    wr(16'h0017, 8'hFF);
    wt(1);
    chk("mki", 8'h01, {7'h00, interrupt_pin_n});
    wr(16'h0018, 8'h00);
    wt(1);
    chk("umi", 8'h00, {7'h00, interrupt_pin_n});
    srst = 1'b1;
    wt(2);
    srst = 1'b0;
    chk("ena", 8'h0F, {4'h0, input_enable});
    chk("ext", 8'h00, {7'h00, ext_ref_clock_select});
    wt(6);
    report_and_stop();
  end
endmodule // ifsm_monitor_tb_top
